// ---- rtl/ssp_pkg.sv ----
// Package for the synchronous serial port: formats, widths, timing counts.
// Assumes a single 50 MHz system clock.
package ssp_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam logic [3:0] SIZE_MIN = 4'h3;
  localparam logic [3:0] CTRL_BITS_M1 = 4'h7;

  // ---------------------------------------------------------------
  // Divider limits
  // ---------------------------------------------------------------
  localparam logic [7:0] PRESCALE_MIN = 8'h02;
  localparam logic [7:0] PRESCALE_MAX = 8'hFE;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int TIMEOUT_BIT_PERIODS = 32;
  localparam logic [5:0] TIMEOUT_LIMIT = 6'h20;

  // ---------------------------------------------------------------
  // Interrupt bit positions
  // ---------------------------------------------------------------
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_TO = 2;
  localparam int IRQ_OR = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  typedef enum logic [1:0] {
    FMT_SPI = 2'b00,
    FMT_PULSED = 2'b01,
    FMT_MESSAGE = 2'b10
  } frame_format_e;

  typedef struct packed {
    logic enable;
    frame_format_e format;
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic loopback;
    logic [3:0] size_m1;
    logic [7:0] prescale_divisor;
    logic [7:0] serial_clock_rate_field;
  } ssp_cfg_s;

  typedef struct packed {
    logic serial_bit_clock_pin;
    logic frame_select_pin;
    logic serial_out_pin;
    logic serial_out_oe;
  } ssp_pins_s;

endpackage

// ---- rtl/ssp_fifo.sv ----
// Eight-entry, sixteen-bit FIFO with registered read data.
// Assumes push and pop come from the same clock domain.
`timescale 1ns/10ps
module ssp_fifo
  import ssp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PUSH,
  input wire logic [WORD_W-1:0] PUSH_DATA,
  input wire logic POP,
  output logic [WORD_W-1:0] POP_DATA,
  output logic EMPTY,
  output logic FULL,
  output logic [PTR_W:0] LEVEL
);

  logic [WORD_W-1:0] mem_reg [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [PTR_W:0] cnt_reg, cnt_next;
  logic [WORD_W-1:0] out_reg, out_next;
  logic do_push, do_pop;

  assign do_push = PUSH && (cnt_reg != 4'h8);
  assign do_pop = POP && (cnt_reg != 4'h0);

  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    out_next = mem_reg[rd_reg];
    if (do_push) begin
      wr_next = wr_reg + 3'h1;
    end
    if (do_pop) begin
      rd_next = rd_reg + 3'h1;
    end
    if (do_push && !do_pop) begin
      cnt_next = cnt_reg + 4'h1;
    end else if (do_pop && !do_push) begin
      cnt_next = cnt_reg - 4'h1;
    end
    if (do_pop) begin
      out_next = mem_reg[rd_reg];
    end else begin
      out_next = out_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_reg <= 3'h0;
      rd_reg <= 3'h0;
      cnt_reg <= 4'h0;
      out_reg <= 16'h0000;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (do_push) begin
      mem_reg[wr_reg] <= PUSH_DATA;
    end
  end

  assign POP_DATA = out_reg;
  assign EMPTY = (cnt_reg == 4'h0);
  assign FULL = (cnt_reg == 4'h8);
  assign LEVEL = cnt_reg;

endmodule

// ---- rtl/sync_serial_port.sv ----
// Synchronous serial port master: transmit and receive FIFOs, bit clock
// divider, three frame formats and four interrupt sources.
// Assumes a 50 MHz clock, configuration held stable while a frame runs.
//
// Notes on behaviour
// - Prescale by even divisor, 2 to 254.
// - Then divide by one plus rate field.
// - Data write pushes into eight-deep transmit FIFO.
// - Data read pops eight-deep receive FIFO.
// - Four interrupt sources ORed into one request.
// - Mask bit one lets source through.
// - Raw and masked status both readable.
// - Frames 4 to 16 bits, MSB first.
// - Bit clock idle except during transfers.
// - Timeout when idle with unread receive data.
// - SPI and message: frame select low whole frame.
// - Pulsed format: one-period high frame pulse.
// - Pulsed format: drive rising, sample falling.
// - Pulsed idle: clock, select low, output tristate.
// - Pulsed: FIFO data starts pulse and load.
// - Pulsed: MSB on rising edge after pulse.
// - Pulsed: word stored at rising edge after LSB.
// - Message: 8-bit control first, nothing received.
// - Polarity bit sets idle clock level in SPI format only.
// - Phase zero samples first edge, one second.
// - Phase zero: select high between words.
// - Phase one, SPI format: select low through continuous words.
`timescale 1ns/10ps
module sync_serial_port
  import ssp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire ssp_cfg_s CFG,
  input wire logic [3:0] IRQ_MASK,
  input wire logic [3:0] IRQ_CLEAR,
  input wire logic DATA_WRITE,
  input wire logic [WORD_W-1:0] DATA_IN,
  input wire logic DATA_READ,
  output logic [WORD_W-1:0] DATA_OUT,
  output logic TX_FULL,
  output logic RX_EMPTY,
  output logic BUSY,
  output logic [3:0] RAW_IRQ_STATUS,
  output logic [3:0] MASKED_IRQ_STATUS,
  output logic IRQ,
  input wire logic SERIAL_IN_PIN,
  output ssp_pins_s PINS
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PULSE = 3'b001,
    ST_SETUP = 3'b010,
    ST_LEAD = 3'b011,
    ST_TRAIL = 3'b100,
    ST_GAP = 3'b101,
    ST_HOLD = 3'b110
  } phase_e;

  // ---------------------------------------------------------------
  // Input synchroniser and loopback
  // ---------------------------------------------------------------
  logic [2:0] rx_sync_reg;
  logic rx_stable_reg, rx_stable_next;
  logic rx_bit;
  always_comb begin
    rx_stable_next = rx_stable_reg;
    if (rx_sync_reg[1] == rx_sync_reg[2]) begin
      rx_stable_next = rx_sync_reg[2];
    end
  end

  // ---------------------------------------------------------------
  // Half bit enable from both dividers
  // ---------------------------------------------------------------
  logic [7:0] pre_reg, pre_next, rate_reg, rate_next;
  logic half_tick, pre_tick;
  logic [7:0] pre_half;
  always_comb begin
    pre_half = {1'b0, CFG.prescale_divisor[7:1]};
    if (CFG.prescale_divisor < PRESCALE_MIN) begin
      pre_half = 8'h01;
    end
    pre_next = pre_reg + 8'h01;
    pre_tick = 1'b0;
    rate_next = rate_reg;
    half_tick = 1'b0;
    if (pre_reg + 8'h01 >= pre_half) begin
      pre_next = 8'h00;
      pre_tick = 1'b1;
      rate_next = rate_reg + 8'h01;
      if (rate_reg == CFG.serial_clock_rate_field) begin
        rate_next = 8'h00;
        half_tick = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // FIFOs
  // ---------------------------------------------------------------
  logic tx_pop, tx_empty, rx_push, rx_full;
  logic [WORD_W-1:0] tx_word, rx_word;
  logic [PTR_W:0] rx_level, tx_level;
  logic tx_pending_reg, tx_pending_next;

  ssp_fifo u_tx_fifo (
    .CLK(CLK), .RST_N(RST_N),
    .PUSH(DATA_WRITE), .PUSH_DATA(DATA_IN),
    .POP(tx_pop), .POP_DATA(tx_word),
    .EMPTY(tx_empty), .FULL(TX_FULL), .LEVEL(tx_level)
  );

  ssp_fifo u_rx_fifo (
    .CLK(CLK), .RST_N(RST_N),
    .PUSH(rx_push), .PUSH_DATA(rx_word),
    .POP(DATA_READ), .POP_DATA(DATA_OUT),
    .EMPTY(RX_EMPTY), .FULL(rx_full), .LEVEL(rx_level)
  );

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  phase_e st_reg, st_next;
  logic [WORD_W-1:0] tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next;
  logic [CNT_W-1:0] bit_reg, bit_next;
  logic ctrl_reg, ctrl_next;
  logic sck_reg, sck_next, fs_reg, fs_next, so_reg, so_next;
  logic oe_reg, oe_next, store_reg, store_next;
  logic [5:0] idle_reg, idle_next;
  logic [3:0] raw_reg, raw_next;
  logic idle_sck, want_store;
  logic [WORD_W-1:0] tx_cur;
  logic [3:0] nbits_m1;

  assign rx_bit = CFG.loopback ? so_reg : rx_stable_reg;
  assign idle_sck = (CFG.format == FMT_SPI) ? CFG.clock_polarity_bit
                                            : 1'b0;
  assign nbits_m1 = (CFG.size_m1 < SIZE_MIN) ? SIZE_MIN : CFG.size_m1;
  assign tx_pop = tx_pending_next && !tx_pending_reg;
  assign rx_word = rx_sh_reg;
  // Popped word appears one cycle after the pop
  assign tx_cur = tx_pending_reg ? tx_word : tx_sh_reg;

  always_comb begin
    st_next = st_reg;
    tx_sh_next = tx_sh_reg;
    rx_sh_next = rx_sh_reg;
    bit_next = bit_reg;
    ctrl_next = ctrl_reg;
    sck_next = sck_reg;
    fs_next = fs_reg;
    so_next = so_reg;
    oe_next = oe_reg;
    store_next = 1'b0;
    tx_pending_next = tx_pending_reg;
    want_store = 1'b0;
    if (!CFG.enable) begin
      st_next = ST_IDLE;
      sck_next = idle_sck;
      fs_next = (CFG.format != FMT_PULSED);
      oe_next = 1'b0;
      tx_pending_next = 1'b0;
    end else if (half_tick) begin
      unique case (st_reg)
        ST_IDLE: begin
          sck_next = idle_sck;
          if (CFG.format == FMT_PULSED) begin
            fs_next = 1'b0;
            oe_next = 1'b0;
            so_next = 1'b0;
          end else begin
            fs_next = 1'b1;
          end
          if (!tx_empty) begin
            tx_pending_next = 1'b1;
            tx_sh_next = tx_word;
            bit_next = (CFG.format == FMT_MESSAGE) ? CTRL_BITS_M1
                                                   : nbits_m1;
            ctrl_next = (CFG.format == FMT_MESSAGE);
            if (CFG.format == FMT_PULSED) begin
              st_next = ST_PULSE;
              sck_next = 1'b1;
              fs_next = 1'b1;
            end else begin
              st_next = ST_SETUP;
              fs_next = 1'b0;
              oe_next = 1'b1;
            end
          end
        end
        ST_PULSE: begin
          tx_pending_next = 1'b0;
          sck_next = ~sck_reg;
          if (!sck_reg) begin
            fs_next = 1'b0;
            oe_next = 1'b1;
            so_next = tx_cur[bit_reg];
            st_next = ST_TRAIL;
          end
        end
        ST_SETUP: begin
          tx_pending_next = 1'b0;
          so_next = ctrl_reg ? tx_cur[bit_reg + 4'h8]
                             : tx_cur[bit_reg];
          sck_next = CFG.clock_phase_bit ? ~idle_sck : idle_sck;
          st_next = ST_LEAD;
        end
        ST_LEAD: begin
          sck_next = ~sck_reg;
          st_next = ST_TRAIL;
          if (!ctrl_reg) begin
            rx_sh_next = {rx_sh_reg[WORD_W-2:0], rx_bit};
          end
        end
        ST_TRAIL: begin
          sck_next = ~sck_reg;
          if (CFG.format == FMT_PULSED && sck_reg) begin
            rx_sh_next = {rx_sh_reg[WORD_W-2:0], rx_bit};
          end else if (bit_reg != 4'h0) begin
            bit_next = bit_reg - 4'h1;
            so_next = ctrl_reg ? tx_sh_reg[bit_reg + 4'h7]
                               : tx_sh_reg[bit_reg - 4'h1];
            st_next = (CFG.format == FMT_PULSED) ? ST_TRAIL : ST_LEAD;
          end else if (ctrl_reg) begin
            ctrl_next = 1'b0;
            bit_next = nbits_m1;
            oe_next = 1'b0;
            st_next = ST_GAP;
          end else begin
            if (CFG.format == FMT_SPI && CFG.clock_phase_bit) begin
              sck_next = sck_reg;
            end
            st_next = ST_HOLD;
            want_store = (CFG.format == FMT_PULSED);
          end
        end
        ST_GAP: begin
          sck_next = ~sck_reg;
          st_next = sck_reg ? ST_LEAD : ST_GAP;
        end
        ST_HOLD: begin
          sck_next = idle_sck;
          want_store = (CFG.format != FMT_PULSED);
          if (CFG.format == FMT_PULSED) begin
            oe_next = tx_empty ? 1'b0 : oe_reg;
          end else if (!tx_empty && CFG.format == FMT_SPI
                       && CFG.clock_phase_bit) begin
            fs_next = 1'b0;
          end else begin
            fs_next = 1'b1;
            oe_next = 1'b0;
          end
          st_next = ST_IDLE;
          if (!tx_empty && !fs_next && CFG.format == FMT_SPI) begin
            tx_pending_next = 1'b1;
            tx_sh_next = tx_word;
            bit_next = nbits_m1;
            st_next = ST_SETUP;
          end
        end
        default: st_next = ST_IDLE;
      endcase
    end else if (st_reg == ST_PULSE || st_reg == ST_SETUP) begin
      tx_pending_next = 1'b0;
    end else if (st_reg == ST_IDLE) begin
      sck_next = idle_sck;
      fs_next = (CFG.format != FMT_PULSED);
      if (CFG.format == FMT_PULSED) begin
        oe_next = 1'b0;
      end
    end
    if (tx_pending_reg) begin
      tx_sh_next = tx_word;
    end
    store_next = want_store;
  end

  // ---------------------------------------------------------------
  // Receive store, timeout and interrupt status
  // ---------------------------------------------------------------
  assign rx_push = store_reg && !rx_full;

  always_comb begin
    idle_next = idle_reg;
    if (st_reg != ST_IDLE || RX_EMPTY || DATA_READ) begin
      idle_next = 6'h00;
    end else if (half_tick && idle_reg != TIMEOUT_LIMIT) begin
      idle_next = idle_reg + 6'h01;
    end
    raw_next = raw_reg & ~IRQ_CLEAR;
    raw_next[IRQ_TX] = (tx_level <= 4'h4);
    raw_next[IRQ_RX] = (rx_level >= 4'h4);
    if (idle_reg == TIMEOUT_LIMIT) begin
      raw_next[IRQ_TO] = 1'b1;
    end
    if (store_reg && rx_full) begin
      raw_next[IRQ_OR] = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    rx_sync_reg <= {rx_sync_reg[1:0], SERIAL_IN_PIN};
    if (!RST_N) begin
      rx_stable_reg <= 1'b0;
      pre_reg <= 8'h00;
      rate_reg <= 8'h00;
      st_reg <= ST_IDLE;
      tx_sh_reg <= 16'h0000;
      rx_sh_reg <= 16'h0000;
      bit_reg <= 4'h0;
      ctrl_reg <= 1'b0;
      sck_reg <= 1'b0;
      fs_reg <= 1'b1;
      so_reg <= 1'b0;
      oe_reg <= 1'b0;
      store_reg <= 1'b0;
      tx_pending_reg <= 1'b0;
      idle_reg <= 6'h00;
      raw_reg <= IRQ_RESET;
    end else begin
      rx_stable_reg <= rx_stable_next;
      pre_reg <= pre_next;
      rate_reg <= rate_next;
      st_reg <= st_next;
      tx_sh_reg <= tx_sh_next;
      rx_sh_reg <= rx_sh_next;
      bit_reg <= bit_next;
      ctrl_reg <= ctrl_next;
      sck_reg <= sck_next;
      fs_reg <= fs_next;
      so_reg <= so_next;
      oe_reg <= oe_next;
      store_reg <= store_next;
      tx_pending_reg <= tx_pending_next;
      idle_reg <= idle_next;
      raw_reg <= raw_next;
    end
  end

  assign RAW_IRQ_STATUS = raw_reg;
  assign MASKED_IRQ_STATUS = raw_reg & IRQ_MASK;
  assign IRQ = |(raw_reg & IRQ_MASK);
  assign BUSY = (st_reg != ST_IDLE) || !tx_empty;
  assign PINS.serial_bit_clock_pin = sck_reg;
  assign PINS.frame_select_pin = fs_reg;
  assign PINS.serial_out_pin = so_reg;
  assign PINS.serial_out_oe = oe_reg;

endmodule

// ---- dv/ssp_slave_model.sv ----
// Peripheral model on the far side of the port's serial pins.
// Port is master; the bench sets the reply word.
`timescale 1ns/10ps
module ssp_slave_model
  import ssp_pkg::*;
(
  input wire ssp_cfg_s cfg,
  input wire ssp_pins_s pins,
  input wire logic [15:0] reply,
  output logic miso,
  output logic [15:0] rx_word
);
  logic [16:0] sh = '0;
  logic spi, lead;
  assign spi = cfg.format != FMT_PULSED;
  // Leading edge leaves the idle level
  assign lead = pins.serial_bit_clock_pin != (spi & cfg.clock_polarity_bit);
  // Released line shows the inverse of its last bit
  assign miso = (spi & pins.frame_select_pin) ? !sh[16] : sh[16];
  initial rx_word = '0;
  function automatic logic [16:0] load(input logic pre);
    logic [15:0] a;
    a = reply << (4'hF - cfg.size_m1);
    return pre ? {1'b0, a} : {a, 1'b0};
  endfunction
  always @(negedge pins.frame_select_pin)
    if (spi) sh = load(cfg.clock_phase_bit);
  always @(pins.serial_bit_clock_pin) begin
    #1;
    if (lead == (cfg.clock_phase_bit | !spi)) begin
      if (!spi && pins.frame_select_pin) sh = load(1'b1);
      else sh = sh << 1;
    end else begin
      rx_word = {rx_word[14:0], pins.serial_out_pin};
    end
  end
endmodule

// ---- dv/ssp_assertions.sv ----
// Checker for the serial port: pins, status and request relations.
// Bound to sync_serial_port; sees its ports only.
`timescale 1ns/10ps
module ssp_checker
  import ssp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire ssp_cfg_s CFG,
  input wire logic [3:0] IRQ_MASK,
  input wire logic [3:0] IRQ_CLEAR,
  input wire logic RX_EMPTY,
  input wire logic BUSY,
  input wire logic [3:0] RAW_IRQ_STATUS,
  input wire logic [3:0] MASKED_IRQ_STATUS,
  input wire logic IRQ,
  input wire ssp_pins_s PINS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ------
  // Gap and pulse counters
  // ------
  logic sck, fs, pul, sck_reg, sck_next, seen_reg, seen_next;
  logic [15:0] gap_reg, gap_next, hi_reg, hi_next, half;
  assign sck = PINS.serial_bit_clock_pin;
  assign fs = PINS.frame_select_pin;
  assign pul = CFG.format == FMT_PULSED;
  assign half = 16'(CFG.prescale_divisor[7:1]) *
    (16'(CFG.serial_clock_rate_field) + 16'h0001);
  always_comb begin
    sck_next = sck;
    seen_next = seen_reg | (sck != sck_reg);
    gap_next = (sck != sck_reg) ? 16'h0000 : gap_reg + 16'h0001;
    hi_next = fs ? hi_reg + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sck_reg <= 1'b0;
      seen_reg <= 1'b0;
      gap_reg <= 16'h0000;
      hi_reg <= 16'h0000;
    end else begin
      sck_reg <= sck_next;
      seen_reg <= seen_next;
      gap_reg <= gap_next;
      hi_reg <= hi_next;
    end
  end
  // ------
  // Properties
  // ------
  a_masked_status:
    assert property (MASKED_IRQ_STATUS == (RAW_IRQ_STATUS & IRQ_MASK))
      else $error("masked status wrong");
  a_irq_combined:
    assert property (IRQ == (|MASKED_IRQ_STATUS))
      else $error("request not OR of masked");
  a_idle_clock:
    assert property (CFG.enable && !BUSY && !$past(BUSY) && $stable(CFG)
      |-> sck == (CFG.format == FMT_SPI && CFG.clock_polarity_bit))
      else $error("bit clock not idle");
  a_pulsed_idle:
    assert property (pul && CFG.enable && !BUSY && !$past(BUSY) &&
      $stable(CFG) |-> !fs && !PINS.serial_out_oe)
      else $error("pulsed idle pins wrong");
  a_select_frame:
    assert property (BUSY && !pul && sck != sck_reg |-> !fs)
      else $error("clock moved without select");
  a_half_period:
    assert property (seen_reg && sck != sck_reg && $stable(CFG)
      |-> gap_reg >= half - 16'h0001)
      else $error("bit clock too fast");
  a_pulse_width:
    assert property (BUSY && pul && $fell(fs)
      |-> hi_reg == {half[14:0], 1'b0})
      else $error("frame pulse width wrong");
  a_overrun_held:
    assert property (RAW_IRQ_STATUS[IRQ_OR] && !IRQ_CLEAR[IRQ_OR]
      |=> RAW_IRQ_STATUS[IRQ_OR])
      else $error("overrun lost");
  a_timeout_data:
    assert property ($rose(RAW_IRQ_STATUS[IRQ_TO]) |-> !RX_EMPTY)
      else $error("timeout with empty fifo");
  c_pulse: cover property (pul && $fell(fs));
  c_overrun: cover property ($rose(RAW_IRQ_STATUS[IRQ_OR]));
  c_timeout: cover property ($rose(RAW_IRQ_STATUS[IRQ_TO]));
endmodule

bind sync_serial_port ssp_checker chk (.CLK, .RST_N, .CFG, .IRQ_MASK,
  .IRQ_CLEAR, .RX_EMPTY, .BUSY, .RAW_IRQ_STATUS, .MASKED_IRQ_STATUS,
  .IRQ, .PINS);

// ---- dv/sync_serial_port_test.sv ----
// Self-checking bench for the serial port with a peripheral model.
// Inputs change at rising CLK; the run ends in end_of_test.
`timescale 1ns/10ps
module sync_serial_port_test
  import ssp_pkg::*;
;
  logic clk, rst_n, wr, rd, si, irq, tx_full, rx_empty, busy, fs_q;
  logic [3:0] mask, clr, raw, msk;
  logic [15:0] din, dout, reply, seen;
  ssp_cfg_s cfg;
  ssp_pins_s pins;
  int n_mismatch, total_checks, cycles, fs_rise;
  sync_serial_port dut (.CLK(clk), .RST_N(rst_n), .CFG(cfg),
    .IRQ_MASK(mask), .IRQ_CLEAR(clr), .DATA_WRITE(wr), .DATA_IN(din),
    .DATA_READ(rd), .DATA_OUT(dout), .TX_FULL(tx_full),
    .RX_EMPTY(rx_empty), .BUSY(busy), .RAW_IRQ_STATUS(raw),
    .MASKED_IRQ_STATUS(msk), .IRQ(irq), .SERIAL_IN_PIN(si), .PINS(pins));
  ssp_slave_model peer (.cfg(cfg), .pins(pins), .reply(reply),
    .miso(si), .rx_word(seen));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ------
  // Helpers
  // ------
  task automatic chk(input string what, input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    fs_q <= pins.frame_select_pin;
    if (pins.frame_select_pin && !fs_q) fs_rise <= fs_rise + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic setup(input frame_format_e f, input logic [3:0] m1,
    input logic pol, pha, lb, en);
    @(posedge clk);
    cfg <= '{en, f, pol, pha, lb, m1, 8'h04, 8'h02};
  endtask
  task automatic put(input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    din <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic get(output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = dout;
  endtask
  task automatic settle;
    int n;
    n = 0;
    while (n < 40) begin
      @(posedge clk);
      n = (busy === 1'b0) ? n + 1 : 0;
    end
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_reset;
    @(posedge clk);
    @(posedge clk);
    #1;
    chk("clk", 16'(pins.serial_bit_clock_pin), 16'h0000);
    chk("fs", 16'(pins.frame_select_pin), 16'h0001);
    chk("raw", 16'(raw), 16'h0001);
    chk("empty", 16'(rx_empty), 16'h0001);
  endtask
  task automatic t_spi_modes;
    logic [15:0] v, m, tx;
    for (int i = 0; i < 4; i++) begin
      m = 16'hFFFF >> (12 - 4 * i);
      tx = 16'hC35A ^ 16'(i);
      setup(FMT_SPI, 4'(4 * i + 3), i[1], i[0], 1'b0, 1'b1);
      put(tx);
      settle();
      get(v);
      chk("spi rx", v & m, reply & m);
      chk("peer rx", seen & m, tx & m);
      chk("idle clk", 16'(pins.serial_bit_clock_pin), 16'(i[1]));
    end
  endtask
  task automatic t_cont(input logic pha);
    logic [15:0] v;
    setup(FMT_SPI, 4'h7, 1'b0, pha, 1'b0, 1'b1);
    fs_rise = 0;
    put(16'h00A6);
    put(16'h0059);
    settle();
    get(v);
    chk("cont rx", v & 16'h00FF, reply & 16'h00FF);
    get(v);
    chk("cont peer", seen & 16'h00FF, 16'h0059);
    chk("fs rises", 16'(fs_rise), pha ? 16'h0001 : 16'h0002);
  endtask
  task automatic t_pulsed;
    logic [15:0] v;
    setup(FMT_PULSED, 4'h9, 1'b0, 1'b0, 1'b0, 1'b1);
    put(16'h02C7);
    settle();
    chk("oe", 16'(pins.serial_out_oe), 16'h0000);
    get(v);
    chk("pulsed rx", v & 16'h03FF, reply & 16'h03FF);
  endtask
  task automatic t_loop;
    logic [15:0] v;
    setup(FMT_SPI, 4'hF, 1'b0, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 9; i++) put(16'h1100 + 16'(i));
    #1;
    chk("tx full", 16'(tx_full), 16'h0001);
    chk("tx svc", 16'(raw[IRQ_TX]), 16'h0000);
    setup(FMT_SPI, 4'hF, 1'b0, 1'b0, 1'b1, 1'b1);
    settle();
    put(16'h2222);
    settle();
    mask <= 4'h8;
    repeat (250) @(posedge clk);
    #1;
    chk("status", 16'(raw), 16'h000F);
    chk("irq on", 16'(irq), 16'h0001);
    @(posedge clk);
    mask <= 4'h0;
    @(posedge clk);
    #1;
    chk("irq off", 16'({irq, msk}), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      get(v);
      chk("loop rx", v, 16'h1100 + 16'(i));
    end
    chk("empty", 16'(rx_empty), 16'h0001);
    @(posedge clk);
    clr <= 4'hC;
    @(posedge clk);
    clr <= 4'h0;
    @(posedge clk);
    #1;
    chk("cleared", 16'(raw), 16'h0001);
  endtask
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    mask = 4'h0;
    clr = 4'h0;
    din = 16'h0000;
    reply = 16'h9B6D;
    fs_q = 1'b1;
    cycles = 0;
    n_mismatch = 0;
    total_checks = 0;
    fs_rise = 0;
    cfg = '{1'b0, FMT_SPI, 1'b0, 1'b0, 1'b0, 4'h7, 8'h04, 8'h02};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_spi_modes();
    t_cont(1'b0);
    t_cont(1'b1);
    t_pulsed();
    t_loop();
    end_of_test();
  end
endmodule
